/* File: hdl/pbc_regs.sv */
// Power budgeting capability register block behind an APB slave port.
// Assumes an APB master on the core clock; one word per register, zero-wait when enabled.
//
// Overview of operation
// - Eight-bit read-write selector, reset zero, picks which budget word is read back.
// - Selector zero to seven: readback returns the whole indexed budget word.
// - Selector above seven: readback returns all zeros.
// - Header holds lockable 16-bit identifier, resets to zero; value 0x4 means power budget.
// - Header holds lockable 4-bit version, resets to zero; value one means version 1.
// - Eight budget words at consecutive words; writes ignored unless value unlock set.
`timescale 1ns/100ps
`include "pbc_params.svh"

module pbc_regs #(
  parameter int AW    = 12,
  parameter int COUNT = `PBC_VALUE_COUNT
) (
  input  wire logic           CLOCK_I,   // Core clock, 40 MHz
  input  wire logic           RST_I,     // Synchronous reset, high
  input  wire logic           CE_I,      // Clock enable, freezes state when low
  input  wire logic           PSEL_I,    // APB select
  input  wire logic           PENABLE_I, // APB enable
  input  wire logic           PWRITE_I,  // APB direction, high for write
  input  wire logic [AW-1:0]  PADDR_I,   // APB byte address
  input  wire logic [31:0]    PWDATA_I,  // APB write data
  output logic      [31:0]    PRDATA_O,  // APB read data, registered
  output logic                PREADY_O,  // APB ready
  output logic                PSLVERR_O  // APB error, unmapped address
);

  localparam int IW = $clog2(COUNT);

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  pbc_pkg::pbc_header_t header;
  pbc_pkg::pbc_index_t  sel;
  logic [1:0]           control;
  logic                 armed;
  logic [31:0]          rd_data;
  logic                 rd_err;

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  wire        aligned     = (PADDR_I[1:0] == 2'h0);
  wire        hit_header  = aligned && (PADDR_I == AW'(`PBC_OFS_HEADER));
  wire        hit_select  = aligned && (PADDR_I == AW'(`PBC_OFS_SELECT));
  wire        hit_read    = aligned && (PADDR_I == AW'(`PBC_OFS_READBACK));
  wire        hit_control = aligned && (PADDR_I == AW'(`PBC_OFS_CONTROL));
  wire [AW-1:0] value_ofs = PADDR_I - AW'(`PBC_OFS_VALUE_BASE);
  wire        hit_value   = aligned && (PADDR_I >= AW'(`PBC_OFS_VALUE_BASE))
                            && (value_ofs < AW'(COUNT * 4));
  wire        mapped      = hit_header || hit_select || hit_read || hit_control || hit_value;
  wire [IW-1:0] value_idx = value_ofs[IW+1:2];
  wire        done        = PSEL_I && PENABLE_I && PREADY_O;
  wire        wr_go       = done && PWRITE_I;
  wire        val_unlock  = control[`PBC_CTL_VAL_UNLOCK];
  wire        hdr_unlock  = control[`PBC_CTL_HDR_UNLOCK];
  wire        capture     = CE_I && PSEL_I && !done;

  pbc_pkg::pbc_word_t sel_word;
  pbc_pkg::pbc_word_t bus_word;
  pbc_pkg::pbc_word_t next_rd_data;

  // Read data is taken while selected and held for the access phase,
  // so PRDATA_O comes from a flop at no cost in wait states.
  assign next_rd_data = hit_header  ? 32'(header)                  :
                        hit_select  ? {24'h00_0000, sel}           :
                        hit_read    ? sel_word                     :
                        hit_control ? {30'h0000_0000, control}     :
                        hit_value   ? bus_word                     :
                                      32'h0000_0000;

  assign PREADY_O = CE_I && PENABLE_I && armed;
  assign PRDATA_O = rd_data;
  assign PSLVERR_O = rd_err && PREADY_O;

  // ----------------------------------------------------------------------------
  // Budget value storage
  // ----------------------------------------------------------------------------
  pbc_value_bank #(
    .COUNT (COUNT)
  ) u_bank (
    .clock_i    (CLOCK_I),
    .rst_i      (RST_I),
    .ce_i       (CE_I),
    .wr_en_i    (wr_go && hit_value),
    .wr_idx_i   (value_idx),
    .wr_data_i  (PWDATA_I),
    .unlock_i   (val_unlock),
    .sel_idx_i  (sel),
    .bus_idx_i  (value_idx),
    .sel_word_o (sel_word),
    .bus_word_o (bus_word)
  );

  // ----------------------------------------------------------------------------
  // Bus handshake and read capture
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      armed   <= 1'b0;
      rd_data <= 32'h0000_0000;
      rd_err  <= 1'b0;
    end else if (CE_I) begin
      armed <= PSEL_I && !done;
      if (capture) begin
        rd_data <= next_rd_data;
        rd_err  <= !mapped;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      header  <= `PBC_HEADER_RST;
      sel     <= `PBC_SELECT_RST;
      control <= `PBC_CONTROL_RST;
    end else if (CE_I && wr_go) begin
      if (hit_header && hdr_unlock) begin
        header <= PWDATA_I;
      end
      if (hit_select) begin
        sel <= PWDATA_I[`PBC_SEL_MSB:0];
      end
      if (hit_control) begin
        control <= PWDATA_I[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  AST_SEL_WRITE: assert property (
    (wr_go && hit_select) |=> (sel == $past(PWDATA_I[7:0])))
    else $error("Selector did not take written value");

  AST_READ_IN_RANGE: assert property (
    (capture && hit_read && sel <= 8'h07) |=>
      (PRDATA_O == $past(u_bank.entry[sel[IW-1:0]])))
    else $error("Readback differs from selected entry");

  AST_READ_OUT_RANGE: assert property (
    (capture && hit_read && sel > 8'h07) |=> (PRDATA_O == 32'h0000_0000))
    else $error("Readback nonzero for out of range selector");

  AST_HDR_RESET: assert property (
    $past(RST_I) |-> (header == `PBC_HEADER_RST))
    else $error("Header not zero after reset");

  AST_HDR_LOCKED: assert property (
    (wr_go && hit_header && !hdr_unlock) |=> $stable(header))
    else $error("Locked header changed");

  AST_VER_WRITE: assert property (
    (wr_go && hit_header && hdr_unlock) |=>
      (header.structure_version == $past(PWDATA_I[19:16])))
    else $error("Version field did not take write");

  AST_VALUE_UNLOCKED: assert property (
    (wr_go && hit_value && val_unlock) |=>
      (u_bank.entry[$past(value_idx)] == $past(PWDATA_I)))
    else $error("Unlocked entry write lost");

  AST_SEL_RSVD_ZERO: assert property (
    (capture && hit_select) |=> (PRDATA_O[31:8] == 24'h00_0000))
    else $error("Selector reserved bits not zero");

  AST_FROZEN_NOT_READY: assert property (
    !CE_I |-> !PREADY_O)
    else $error("Ready raised with clock enable low");

  COV_READ_IN_RANGE:  cover property (capture && hit_read && sel <= 8'h07 && !PWRITE_I);
  COV_READ_OUT_RANGE: cover property (capture && hit_read && sel > 8'h07 && !PWRITE_I);
  COV_LOCKED_VALUE:   cover property (wr_go && hit_value && !val_unlock);
  COV_HEADER_WRITE:   cover property (wr_go && hit_header && hdr_unlock);

endmodule : pbc_regs

/* File: inc/pbc_params.svh */
// Offsets, field positions, reset values and counts of the power budget register block.
// Assumes a 12-bit byte address space of 32-bit words on the register bus.
`ifndef PBC_PARAMS_SVH
`define PBC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PBC_OFS_HEADER     12'h0280
`define PBC_OFS_SELECT     12'h0284
`define PBC_OFS_READBACK   12'h0288
`define PBC_OFS_VALUE_BASE 12'h0300
`define PBC_OFS_CONTROL    12'h0404

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PBC_CAP_IDENTIFIER_MSB      15
`define PBC_CAP_IDENTIFIER_LSB      0
`define PBC_VER_MSB        19
`define PBC_VER_LSB        16
`define PBC_NEXT_MSB       31
`define PBC_NEXT_LSB       20
`define PBC_SEL_MSB        7
`define PBC_CTL_VAL_UNLOCK 0
`define PBC_CTL_HDR_UNLOCK 1

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define PBC_HEADER_RST     32'h0000_0000
`define PBC_SELECT_RST     8'h00
`define PBC_CONTROL_RST    2'h0
`define PBC_VALUE_RST      32'h0000_0000
`define PBC_VALUE_COUNT    8
`define PBC_CAP_IDENTIFIER_POWER    16'h0004
`define PBC_VER_ONE        4'h1

`endif

/* File: inc/pbc_pkg.sv */
// Types shared by the power budget register block.
// Assumes 32-bit register words.
package pbc_pkg;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef logic [31:0] pbc_word_t;
  typedef logic [7:0]  pbc_index_t;

  typedef struct packed {
    logic [11:0] next_structure_pointer;
    logic [3:0]  structure_version;
    logic [15:0] cap_identifier;
  } pbc_header_t;

endpackage : pbc_pkg

/* File: hdl/pbc_value_bank.sv */
// Storage for the selectable budget value entries, with a select port and a bus port.
// Assumes writes arrive as single-cycle strobes from the register decoder on the same clock.
`timescale 1ns/100ps
`include "pbc_params.svh"

module pbc_value_bank #(
  parameter int COUNT = `PBC_VALUE_COUNT,
  parameter int IW    = $clog2(COUNT)
) (
  input  wire logic                clock_i,    // Core clock
  input  wire logic                rst_i,      // Synchronous reset, high
  input  wire logic                ce_i,       // Clock enable
  input  wire logic                wr_en_i,    // Bus write strobe to an entry
  input  wire logic [IW-1:0]       wr_idx_i,   // Entry written
  input  wire pbc_pkg::pbc_word_t  wr_data_i,  // Write data
  input  wire logic                unlock_i,   // Entry write unlock
  input  wire pbc_pkg::pbc_index_t sel_idx_i,  // Selector value
  input  wire logic [IW-1:0]       bus_idx_i,  // Entry read directly by the bus
  output pbc_pkg::pbc_word_t       sel_word_o, // Selected word or zero
  output pbc_pkg::pbc_word_t       bus_word_o  // Directly addressed word
);

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  pbc_pkg::pbc_word_t entry [COUNT];
  logic               sel_ok;

  function automatic logic in_range(input pbc_pkg::pbc_index_t idx);
    in_range = (idx < 8'(COUNT));
  endfunction : in_range

  assign sel_ok     = in_range(sel_idx_i);
  assign sel_word_o = sel_ok ? entry[sel_idx_i[IW-1:0]] : '0;
  assign bus_word_o = entry[bus_idx_i];

  // Locked writes simply do not reach the array
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      for (int i = 0; i < COUNT; i++) begin
        entry[i] <= `PBC_VALUE_RST;
      end
    end else if (ce_i && wr_en_i && unlock_i) begin
      entry[wr_idx_i] <= wr_data_i;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_LOCKED_ENTRY_HOLDS: assert property (@(posedge clock_i) disable iff (rst_i)
    (ce_i && wr_en_i && !unlock_i) |=> (entry[$past(wr_idx_i)] == $past(entry[wr_idx_i])))
    else $error("Locked budget entry changed on a write");

  AST_OUT_RANGE_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
    (sel_idx_i > 8'h07) |-> (sel_word_o == 32'h0000_0000))
    else $error("Out of range selector returned nonzero data");

endmodule : pbc_value_bank

/* File: test/pbc_regs_bench.sv */
// Self-checking bench for the power budget register block, random stimulus with corner cases.
// Assumes pbc_regs with default parameters; this file acts as the APB master.
`timescale 1ns/100ps
`include "pbc_params.svh"

module pbc_regs_bench;
  logic        clock;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          num_errors;
  int          checks_done;
  int          cycles;
  int          seed;
  int          i;
  logic        ce_jitter;
  logic [31:0] model [8];
  logic [31:0] rd;
  logic        err;
  logic [7:0]  sel;
  logic [31:0] wd;

  pbc_regs DUT (
    .CLOCK_I   (clock),
    .RST_I     (rst),
    .CE_I      (ce),
    .PSEL_I    (psel),
    .PENABLE_I (penable),
    .PWRITE_I  (pwrite),
    .PADDR_I   (paddr),
    .PWDATA_I  (pwdata),
    .PRDATA_O  (prdata),
    .PREADY_O  (pready),
    .PSLVERR_O (pslverr)
  );

  initial clock = 1'b0;
  always #12.5 clock = ~clock;

  // ----------------------------------------------------------------------------
  // Clock enable stalls and hang guard
  // ----------------------------------------------------------------------------
  always @(posedge clock) begin
    cycles <= cycles + 1;
    ce     <= ce_jitter ? ($random(seed) % 4 != 0) : 1'b1;
    if (cycles == 6000) begin
      num_errors++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One APB transfer; stalls may stretch it, only the cycle guard ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, {err, rd}, {1'b0, exp});
  endtask : rdchk

  function automatic logic [31:0] exp_rb(input logic [7:0] s);
    return (s > 8'h07) ? 32'h0000_0000 : model[s[2:0]];
  endfunction : exp_rb

  function automatic logic [11:0] ent(input int k);
    return `PBC_OFS_VALUE_BASE + 12'(k * 4);
  endfunction : ent

  initial begin
    seed = 32'h2341;
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0000;
    pwdata = 32'h0000_0000;
    ce_jitter = 1'b0;
    num_errors = 0;
    checks_done = 0;
    cycles = 0;
    for (i = 0; i < 8; i++) model[i] = 32'h0000_0000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rdchk("header", `PBC_OFS_HEADER, `PBC_HEADER_RST);
    rdchk("select", `PBC_OFS_SELECT, 32'h0000_0000);
    rdchk("readback", `PBC_OFS_READBACK, 32'h0000_0000);
    $display("test reset values done");
    // Locked: header and entries must keep their reset contents
    wr(`PBC_OFS_HEADER, 32'h0011_0004);
    rdchk("header", `PBC_OFS_HEADER, 32'h0000_0000);
    for (i = 0; i < 8; i++) begin
      wr(ent(i), $random(seed));
      rdchk("entry", ent(i), 32'h0000_0000);
    end
    $display("test locked writes done");
    wr(`PBC_OFS_CONTROL, 32'h0000_0003);
    rdchk("control", `PBC_OFS_CONTROL, 32'h0000_0003);
    wr(`PBC_OFS_HEADER, 32'hABC1_0004);
    rdchk("header", `PBC_OFS_HEADER, 32'hABC1_0004);
    for (i = 0; i < 8; i++) begin
      model[i] = $random(seed);
      wr(ent(i), model[i]);
      rdchk("entry", ent(i), model[i]);
    end
    $display("test unlocked writes done");
    // Selector sweep under clock-enable stalls, with junk in the reserved bits
    ce_jitter = 1'b1;
    for (i = 0; i < 24; i++) begin
      sel = (i < 8) ? i[7:0] : (i == 8) ? 8'h08 : (i == 9) ? 8'hFF : 8'($random(seed));
      wd = $random(seed);
      wd[7:0] = sel;
      wr(`PBC_OFS_SELECT, wd);
      rdchk("select", `PBC_OFS_SELECT, {24'h00_0000, sel});
      wr(`PBC_OFS_READBACK, ~wd);
      rdchk("readback", `PBC_OFS_READBACK, exp_rb(sel));
    end
    ce_jitter = 1'b0;
    $display("test selector sweep done");
    apb(1'b0, 12'h0104, 32'h0000_0000);
    check("unmapped", {err, rd}, {1'b1, 32'h0000_0000});
    apb(1'b1, 12'h0281, 32'hFFFF_FFFF);
    check("misaligned", {1'b0, err}, {1'b0, 32'h0000_0001});
    rdchk("header", `PBC_OFS_HEADER, 32'hABC1_0004);
    $display("test refused access done");
    wr(`PBC_OFS_CONTROL, 32'h0000_0000);
    wr(ent(1), ~model[1]);
    rdchk("entry", ent(1), model[1]);
    wr(`PBC_OFS_SELECT, 32'h0000_0001);
    rdchk("readback", `PBC_OFS_READBACK, model[1]);
    wr(`PBC_OFS_HEADER, 32'h0000_0000);
    rdchk("header", `PBC_OFS_HEADER, 32'hABC1_0004);
    $display("test relock done");
    give_verdict();
  end
endmodule : pbc_regs_bench
